/* rtl/dcd_command_decoder.sv */
// What this block does
// - Command from select, strobes, clock-enable at edge
// - Active-low reset is asynchronous only
// - Termination control never affects decoding
// - Bank operations hit only the addressed bank, except close all rows, which closes every bank
// - Mode load: bank picks one of four
// - Self-renew exit recognised without command clocking
// - Started bursts always run to completion
// - Mode register zero picks fixed or per-command size
// - Idle registers nothing, running work continues
// - Deselect behaves exactly like idle
// - No self refresh during sleep power-down
// - First long calibration initial, later operational
// - Bank, row, column widths follow configuration
// - Bit ten on access selects auto precharge
// - Per-command size: bit twelve low chops four
// - Row open stays open until precharged
`timescale 1ns/10ps
`include "dcd_defines.svh"

module dcd_command_decoder
  import dcd_pkg::*;
#(
  parameter int ADDR_W = 16,
  parameter int BANK_W = 3,
  parameter int ROW_W  = 16,
  parameter int COL_W  = 10
) (
  // Clock and reset
  input  wire logic              ref_clk,
  input  wire logic              rst_b,
  // Command pins from the controller
  input  wire logic              chipSelect_b,
  input  wire logic              rowStrobe_b,
  input  wire logic              colStrobe_b,
  input  wire logic              writeEnable_b,
  input  wire logic              clockEnable,
  input  wire logic [BANK_W-1:0] bankAddr,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic              termination_control,
  // Decoded command
  output dcd_cmd_t               cmdCode_ff,
  output logic                   cmdValid_ff,
  output logic      [BANK_W-1:0] cmdBank_ff,
  output logic      [ROW_W-1:0]  cmdRow_ff,
  output logic      [COL_W-1:0]  cmdCol_ff,
  output logic                   autoPrecharge_ff,
  output logic                   chopped_four_burst_ff,
  // Device state
  output dcd_pwr_t               pwrState_ff,
  output logic [(1<<BANK_W)-1:0] bankOpen_ff,
  output logic                   burstBusy,
  output logic                   calInit_ff,
  output logic                   calOper_ff,
  output logic                   calShort_ff,
  output logic      [ADDR_W-1:0] mode_register_zero
);

  localparam int NBANK = 1 << BANK_W;
  localparam int PIN_W = 5 + BANK_W + ADDR_W;

  // Field widths follow configuration
  if (COL_W < 10 || COL_W > 11 || ROW_W > ADDR_W || ADDR_W < 13 ||
      BANK_W < 2) begin : g_bad_cfg
    $error("dcd_command_decoder: unsupported address configuration");
  end

  // Column from A[9:0], with A11 above it in wide-column parts
  function automatic logic [COL_W-1:0] colOf(input logic [ADDR_W-1:0] a);
    logic [10:0] c;
    c = {a[11], a[9:0]};
    return c[COL_W-1:0];
  endfunction

  // Idle or deselect on the sampled pins
  function automatic logic isQuiet(input logic cs, input logic [2:0] pat);
    return cs || (pat == `DCD_PAT_IDLE);
  endfunction

  // Two-stage synchronisers on all pins; termination control not sampled
  logic [PIN_W-1:0] pinMeta_ff;
  logic [PIN_W-1:0] pinSync_ff;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pinMeta_ff <= '0;
      pinSync_ff <= '0;
    end else begin
      pinMeta_ff <= {clockEnable, chipSelect_b, rowStrobe_b, colStrobe_b,
                     writeEnable_b, bankAddr, addr};
      pinSync_ff <= pinMeta_ff;
    end
  end

  logic              ckeNow;
  logic              csNow;
  logic [2:0]        patNow;
  logic [BANK_W-1:0] baNow;
  logic [ADDR_W-1:0] aNow;
  logic              ckePrev_ff;

  assign {ckeNow, csNow, patNow, baNow, aNow} = pinSync_ff;

  // Clock-enable level at the previous edge
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ckePrev_ff <= 1'b0;
    end else begin
      ckePrev_ff <= ckeNow;
    end
  end

  logic       burstDone;
  logic [1:0] sizeMode;

  assign sizeMode = mode_register_zero[`DCD_MR0_SIZE_MSB:`DCD_MR0_SIZE_LSB];

  // Command classification
  dcd_cmd_t nxtCmd;

  always_comb begin
    nxtCmd = CMD_NONE;
    case (pwrState_ff)
      PWR_ACTIVE: begin
        if (ckePrev_ff && ckeNow) begin
          if (csNow) begin
            nxtCmd = CMD_IDLE;
          end else begin
            case (patNow)
              `DCD_PAT_MODE_LOAD: nxtCmd = CMD_MODE_LOAD;
              `DCD_PAT_REFRESH:   nxtCmd = CMD_REFRESH;
              `DCD_PAT_PRECHARGE: begin
                nxtCmd = aNow[`DCD_PRECHARGE_FLAG_BIT] ? CMD_CLOSE_ALL_ROWS
                                                       : CMD_PRECHARGE;
              end
              `DCD_PAT_ROW_OPEN:  nxtCmd = CMD_ROW_OPEN;
              `DCD_PAT_WRITE:     nxtCmd = burstBusy ? CMD_NONE : CMD_WRITE;
              `DCD_PAT_READ:      nxtCmd = burstBusy ? CMD_NONE : CMD_READ;
              `DCD_PAT_CALIBRATION: begin
                nxtCmd = aNow[`DCD_PRECHARGE_FLAG_BIT] ? CMD_LONG_CALIBRATION
                                                       : CMD_SHORT_CALIBRATION;
              end
              default:            nxtCmd = CMD_IDLE;
            endcase
          end
        end else if (ckePrev_ff && !ckeNow) begin
          if (!csNow && patNow == `DCD_PAT_REFRESH) begin
            nxtCmd = CMD_SELF_RENEW_ENTRY;
          end else if (isQuiet(csNow, patNow)) begin
            nxtCmd = CMD_SLEEP_ENTRY;
          end
        end
      end
      PWR_SLEEP: begin
        if (!ckePrev_ff && ckeNow && isQuiet(csNow, patNow)) begin
          nxtCmd = CMD_SLEEP_EXIT;
        end
      end
      PWR_SELF: begin
        // Exit taken from clock-enable alone, command pins not needed
        if (ckeNow) begin
          nxtCmd = CMD_SELF_RENEW_EXIT;
        end
      end
      default: nxtCmd = CMD_NONE;
    endcase
  end

  logic nxtAccess;
  logic nxtChop;

  assign nxtAccess = (nxtCmd == CMD_READ) || (nxtCmd == CMD_WRITE);

  // Burst size from mode register zero or per command
  always_comb begin
    case (sizeMode)
      `DCD_SIZE_PER_COMMAND: nxtChop = !aNow[`DCD_CHOP_SELECT_BIT];
      `DCD_SIZE_FIXED_FOUR:  nxtChop = 1'b1;
      default:               nxtChop = 1'b0;
    endcase
  end

  // Registered command outputs
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cmdCode_ff            <= CMD_NONE;
      cmdValid_ff           <= 1'b0;
      cmdBank_ff            <= '0;
      cmdRow_ff             <= '0;
      cmdCol_ff             <= '0;
      autoPrecharge_ff      <= 1'b0;
      chopped_four_burst_ff <= 1'b0;
    end else begin
      cmdCode_ff            <= nxtCmd;
      cmdValid_ff           <= (nxtCmd != CMD_NONE) && (nxtCmd != CMD_IDLE);
      cmdBank_ff            <= baNow;
      cmdRow_ff             <= aNow[ROW_W-1:0];
      cmdCol_ff             <= colOf(aNow);
      autoPrecharge_ff      <= nxtAccess && aNow[`DCD_PRECHARGE_FLAG_BIT];
      chopped_four_burst_ff <= nxtAccess && nxtChop;
    end
  end

  // Power state; no internal refresh is scheduled while asleep
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pwrState_ff <= PWR_ACTIVE;
    end else begin
      case (nxtCmd)
        CMD_SELF_RENEW_ENTRY: pwrState_ff <= PWR_SELF;
        CMD_SLEEP_ENTRY:      pwrState_ff <= PWR_SLEEP;
        CMD_SLEEP_EXIT:       pwrState_ff <= PWR_ACTIVE;
        CMD_SELF_RENEW_EXIT:  pwrState_ff <= PWR_ACTIVE;
        default:              pwrState_ff <= pwrState_ff;
      endcase
    end
  end

  // Mode registers, bank address selects the word
  dcd_mode_mem #(
    .WIDTH (ADDR_W),
    .DEPTH (`DCD_MODE_REG_COUNT)
  ) u_mode_mem (
    .ref_clk   (ref_clk),
    .rst_b     (rst_b),
    .wrEn      (nxtCmd == CMD_MODE_LOAD),
    .wrAddr    (baNow[1:0]),
    .wrData    (aNow),
    .rdAddr    (2'h0),
    .rdData_ff (mode_register_zero)
  );

  // Burst runs its full length once started
  dcd_burst_timer #(
    .CNT_W (3)
  ) u_burst_timer (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .start   (nxtAccess),
    .clocks  (nxtChop ? `DCD_CHOPPED_FOUR_CLKS : `DCD_FULL_EIGHT_CLKS),
    .busy_ff (burstBusy),
    .done_ff (burstDone)
  );

  // Pending auto precharge of the burst's bank
  logic              apPend_ff;
  logic [BANK_W-1:0] apBank_ff;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      apPend_ff <= 1'b0;
      apBank_ff <= '0;
    end else if (nxtAccess) begin
      apPend_ff <= aNow[`DCD_PRECHARGE_FLAG_BIT];
      apBank_ff <= baNow;
    end else if (burstDone) begin
      apPend_ff <= 1'b0;
    end
  end

  // Open-row tracking per bank
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      bankOpen_ff <= '0;
    end else begin
      for (int b = 0; b < NBANK; b++) begin
        if (nxtCmd == CMD_ROW_OPEN && baNow == BANK_W'(b)) begin
          bankOpen_ff[b] <= 1'b1;
        end else if (nxtCmd == CMD_CLOSE_ALL_ROWS) begin
          bankOpen_ff[b] <= 1'b0;
        end else if (nxtCmd == CMD_PRECHARGE && baNow == BANK_W'(b)) begin
          bankOpen_ff[b] <= 1'b0;
        end else if (burstDone && apPend_ff && apBank_ff == BANK_W'(b)) begin
          bankOpen_ff[b] <= 1'b0;
        end
      end
    end
  end

  // Calibration kind; first long one is the initial calibration
  logic initDone_ff;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      initDone_ff <= 1'b0;
      calInit_ff  <= 1'b0;
      calOper_ff  <= 1'b0;
      calShort_ff <= 1'b0;
    end else begin
      calInit_ff  <= (nxtCmd == CMD_LONG_CALIBRATION) && !initDone_ff;
      calOper_ff  <= (nxtCmd == CMD_LONG_CALIBRATION) && initDone_ff;
      calShort_ff <= (nxtCmd == CMD_SHORT_CALIBRATION);
      if (nxtCmd == CMD_LONG_CALIBRATION) begin
        initDone_ff <= 1'b1;
      end
    end
  end

  // Deselect registers nothing
  property p_deselect_quiet;
    @(posedge ref_clk) disable iff (!rst_b)
      (pwrState_ff == PWR_ACTIVE && ckePrev_ff && ckeNow && csNow)
      |=> !cmdValid_ff && cmdCode_ff == CMD_IDLE;
  endproperty
  a_deselect_quiet: assert property (p_deselect_quiet)
    else $error("deselect produced a command");

  // Idle leaves a running burst running
  property p_idle_keeps_burst;
    @(posedge ref_clk) disable iff (!rst_b)
      (burstBusy && !burstDone && nxtCmd == CMD_IDLE) |=> !cmdValid_ff;
  endproperty
  a_idle_keeps_burst: assert property (p_idle_keeps_burst)
    else $error("idle registered an operation");

  // Full burst occupies exactly four clocks
  property p_full_burst;
    @(posedge ref_clk) disable iff (!rst_b)
      (cmdValid_ff && cmdCode_ff == CMD_READ && !chopped_four_burst_ff)
      |-> burstBusy [*4] ##1 !burstBusy;
  endproperty
  a_full_burst: assert property (p_full_burst)
    else $error("burst length wrong");

  // Auto precharge closes the bank at burst end
  property p_auto_close;
    @(posedge ref_clk) disable iff (!rst_b)
      (burstDone && apPend_ff && nxtCmd != CMD_ROW_OPEN)
      |=> !bankOpen_ff[$past(apBank_ff)];
  endproperty
  a_auto_close: assert property (p_auto_close)
    else $error("auto precharge did not close bank");

  // Refresh with falling clock-enable enters self-renew
  property p_self_entry;
    @(posedge ref_clk) disable iff (!rst_b)
      (pwrState_ff == PWR_ACTIVE && ckePrev_ff && !ckeNow && !csNow &&
       patNow == `DCD_PAT_REFRESH) |=> pwrState_ff == PWR_SELF;
  endproperty
  a_self_entry: assert property (p_self_entry)
    else $error("self-renew entry missed");

  // Clock-enable high leaves self-renew whatever the command pins
  property p_self_exit;
    @(posedge ref_clk) disable iff (!rst_b)
      (pwrState_ff == PWR_SELF && ckeNow)
      |=> pwrState_ff == PWR_ACTIVE && cmdCode_ff == CMD_SELF_RENEW_EXIT;
  endproperty
  a_self_exit: assert property (p_self_exit)
    else $error("self-renew exit missed");

  // Initial calibration only once after reset
  property p_cal_init_once;
    @(posedge ref_clk) disable iff (!rst_b)
      calInit_ff |-> cmdCode_ff == CMD_LONG_CALIBRATION && !$past(initDone_ff);
  endproperty
  a_cal_init_once: assert property (p_cal_init_once)
    else $error("initial calibration repeated");

  // Row open marks the addressed bank
  property p_row_open_bank;
    @(posedge ref_clk) disable iff (!rst_b)
      (cmdValid_ff && cmdCode_ff == CMD_ROW_OPEN) |-> bankOpen_ff[cmdBank_ff];
  endproperty
  a_row_open_bank: assert property (p_row_open_bank)
    else $error("row open did not mark its bank");

endmodule // dcd_command_decoder

/* rtl/dcd_defines.svh */
`ifndef DCD_DEFINES_SVH
`define DCD_DEFINES_SVH

// Strobe patterns {row, column, write}, active-low levels
`define DCD_PAT_MODE_LOAD   3'h0
`define DCD_PAT_REFRESH     3'h1
`define DCD_PAT_PRECHARGE   3'h2
`define DCD_PAT_ROW_OPEN    3'h3
`define DCD_PAT_WRITE       3'h4
`define DCD_PAT_READ        3'h5
`define DCD_PAT_CALIBRATION 3'h6
`define DCD_PAT_IDLE        3'h7

// Address bit positions sampled with a command
`define DCD_PRECHARGE_FLAG_BIT 10
`define DCD_CHOP_SELECT_BIT    12

// Burst size field of mode register zero
`define DCD_MR0_SIZE_LSB    0
`define DCD_MR0_SIZE_MSB    1
`define DCD_SIZE_FIXED_EIGHT 2'h0
`define DCD_SIZE_PER_COMMAND 2'h1
`define DCD_SIZE_FIXED_FOUR  2'h2

// Burst length in clocks (two beats per clock)
`define DCD_FULL_EIGHT_CLKS  3'h4
`define DCD_CHOPPED_FOUR_CLKS 3'h2

// Reset values
`define DCD_MODE_REG_RESET  16'h0000
`define DCD_MODE_REG_COUNT  4

`endif

/* rtl/dcd_pkg.sv */
package dcd_pkg;

  // Decoded command classes
  typedef enum logic [3:0] {
    CMD_NONE              = 4'h0,
    CMD_MODE_LOAD         = 4'h1,
    CMD_REFRESH           = 4'h2,
    CMD_PRECHARGE         = 4'h3,
    CMD_CLOSE_ALL_ROWS    = 4'h4,
    CMD_ROW_OPEN          = 4'h5,
    CMD_WRITE             = 4'h6,
    CMD_READ              = 4'h7,
    CMD_LONG_CALIBRATION  = 4'h8,
    CMD_SHORT_CALIBRATION = 4'h9,
    CMD_SELF_RENEW_ENTRY  = 4'ha,
    CMD_SELF_RENEW_EXIT   = 4'hb,
    CMD_SLEEP_ENTRY       = 4'hc,
    CMD_SLEEP_EXIT        = 4'hd,
    CMD_IDLE              = 4'he
  } dcd_cmd_t;

  // Power states
  typedef enum logic [1:0] {
    PWR_ACTIVE = 2'h0,
    PWR_SLEEP  = 2'h1,
    PWR_SELF   = 2'h2
  } dcd_pwr_t;

endpackage

/* rtl/dcd_mode_mem.sv */
`timescale 1ns/10ps
`include "dcd_defines.svh"

module dcd_mode_mem
  import dcd_pkg::*;
#(
  parameter int WIDTH = 16,
  parameter int DEPTH = `DCD_MODE_REG_COUNT
) (
  // Clock and reset
  input  wire logic                     ref_clk,
  input  wire logic                     rst_b,
  // Write port
  input  wire logic                     wrEn,
  input  wire logic [$clog2(DEPTH)-1:0] wrAddr,
  input  wire logic [WIDTH-1:0]         wrData,
  // Read port, registered
  input  wire logic [$clog2(DEPTH)-1:0] rdAddr,
  output logic      [WIDTH-1:0]         rdData_ff
);

  if (DEPTH < 2 || WIDTH < 2) begin : g_bad_size
    $error("dcd_mode_mem: size too small");
  end

  logic [WIDTH-1:0] mem_ff [DEPTH];

  // Storage words
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_ff[i] <= WIDTH'(`DCD_MODE_REG_RESET);
      end
    end else if (wrEn) begin
      mem_ff[wrAddr] <= wrData;
    end
  end

  // Registered read
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdData_ff <= WIDTH'(`DCD_MODE_REG_RESET);
    end else begin
      rdData_ff <= mem_ff[rdAddr];
    end
  end

endmodule // dcd_mode_mem

/* rtl/dcd_burst_timer.sv */
`timescale 1ns/10ps

module dcd_burst_timer
  import dcd_pkg::*;
#(
  parameter int CNT_W = 3
) (
  // Clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rst_b,
  // Burst start
  input  wire logic             start,
  input  wire logic [CNT_W-1:0] clocks,
  // Status
  output logic                  busy_ff,
  output logic                  done_ff
);

  if (CNT_W < 2) begin : g_bad_width
    $error("dcd_burst_timer: counter too narrow");
  end

  logic [CNT_W-1:0] cnt_ff;

  // Runs a started burst to its end; a start while busy is ignored
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
      cnt_ff  <= '0;
    end else begin
      done_ff <= 1'b0;
      if (!busy_ff && start) begin
        busy_ff <= 1'b1;
        cnt_ff  <= clocks - CNT_W'(1);
      end else if (busy_ff) begin
        if (cnt_ff == '0) begin
          busy_ff <= 1'b0;
          done_ff <= 1'b1;
        end else begin
          cnt_ff <= cnt_ff - CNT_W'(1);
        end
      end
    end
  end

endmodule // dcd_burst_timer

/* bench/dcd_ctrl_model.sv */
`timescale 1ns/10ps

module dcd_ctrl_model (
  // Clock
  input  wire logic   ref_clk,
  // Command pins toward the decoder
  output logic        chipSelect_b,
  output logic        rowStrobe_b,
  output logic        colStrobe_b,
  output logic        writeEnable_b,
  output logic        clockEnable,
  output logic [2:0]  bankAddr,
  output logic [15:0] addr
);
  // Pins start deselected with clock-enable high
  initial begin
    {chipSelect_b, rowStrobe_b, colStrobe_b, writeEnable_b} = 4'hf;
    clockEnable = 1'h1;
    bankAddr = 3'h0;
    addr = 16'h0000;
  end

  // One command slot, launched just after a rising edge
  task automatic drive(input logic cs, input logic [2:0] pat, input logic ke,
                       input logic [2:0] ba, input logic [15:0] a);
    @(posedge ref_clk);
    chipSelect_b <= cs;
    clockEnable <= ke;
    if (cs) begin
      // Deselected: strobes and address mean nothing, so they keep moving
      {rowStrobe_b, colStrobe_b, writeEnable_b} <= ~{rowStrobe_b, colStrobe_b, writeEnable_b};
      bankAddr <= ~bankAddr;
      addr <= ~addr;
    end else begin
      {rowStrobe_b, colStrobe_b, writeEnable_b} <= pat;
      bankAddr <= ba;
      addr <= a;
    end
  endtask
endmodule // dcd_ctrl_model

/* bench/dcd_command_decoder_tb.sv */
`timescale 1ns/10ps
`include "dcd_defines.svh"

module dcd_command_decoder_tb
  import dcd_pkg::*;
;
  logic ref_clk = 1'h0;
  logic rst_b = 1'h0;
  logic termCtl = 1'h0;
  logic chipSelect_b, rowStrobe_b, colStrobe_b, writeEnable_b, clockEnable;
  logic [2:0] bankAddr, cmdBank_ff;
  logic [15:0] addr, cmdRow_ff, mode_register_zero, mr0;
  logic [9:0] cmdCol_ff;
  dcd_cmd_t cmdCode_ff, e;
  dcd_pwr_t pwrState_ff;
  logic [7:0] bankOpen_ff, openMask;
  logic cmdValid_ff, autoPrecharge_ff, chopped_four_burst_ff, burstBusy;
  logic calInit_ff, calOper_ff, calShort_ff, longSeen, cs, chop;
  logic [31:0] seed = 32'h0000_0023;
  logic [31:0] r;
  logic [2:0] pat, ba;
  logic [15:0] a;
  int error_cnt = 0;
  int cmp_count = 0;
  int cnt;

  // Clock at 125 MHz
  initial begin
    forever #4 ref_clk = ~ref_clk;
  end

  dcd_command_decoder dcd_command_decoder_i (
    .ref_clk(ref_clk), .rst_b(rst_b), .chipSelect_b(chipSelect_b),
    .rowStrobe_b(rowStrobe_b), .colStrobe_b(colStrobe_b), .writeEnable_b(writeEnable_b),
    .clockEnable(clockEnable), .bankAddr(bankAddr), .addr(addr),
    .termination_control(termCtl), .cmdCode_ff(cmdCode_ff), .cmdValid_ff(cmdValid_ff),
    .cmdBank_ff(cmdBank_ff), .cmdRow_ff(cmdRow_ff), .cmdCol_ff(cmdCol_ff),
    .autoPrecharge_ff(autoPrecharge_ff), .chopped_four_burst_ff(chopped_four_burst_ff),
    .pwrState_ff(pwrState_ff), .bankOpen_ff(bankOpen_ff), .burstBusy(burstBusy),
    .calInit_ff(calInit_ff), .calOper_ff(calOper_ff), .calShort_ff(calShort_ff),
    .mode_register_zero(mode_register_zero));

  dcd_ctrl_model dcd_ctrl_model_i (
    .ref_clk(ref_clk), .chipSelect_b(chipSelect_b), .rowStrobe_b(rowStrobe_b),
    .colStrobe_b(colStrobe_b), .writeEnable_b(writeEnable_b), .clockEnable(clockEnable),
    .bankAddr(bankAddr), .addr(addr));

  // Repeatable random source
  function logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Expected class of a sampled command
  function dcd_cmd_t expCmd(input logic c, input logic [2:0] p, input logic a10);
    if (c) return CMD_IDLE;
    case (p)
      `DCD_PAT_MODE_LOAD:   return CMD_MODE_LOAD;
      `DCD_PAT_REFRESH:     return CMD_REFRESH;
      `DCD_PAT_PRECHARGE:   return a10 ? CMD_CLOSE_ALL_ROWS : CMD_PRECHARGE;
      `DCD_PAT_ROW_OPEN:    return CMD_ROW_OPEN;
      `DCD_PAT_WRITE:       return CMD_WRITE;
      `DCD_PAT_READ:        return CMD_READ;
      `DCD_PAT_CALIBRATION: return a10 ? CMD_LONG_CALIBRATION : CMD_SHORT_CALIBRATION;
      default:              return CMD_IDLE;
    endcase
  endfunction

  // Expected four-beat burst from the mode word and bit twelve
  function logic expChop(input logic [15:0] m, input logic a12);
    return (m[1:0] == `DCD_SIZE_FIXED_FOUR) || (m[1:0] == `DCD_SIZE_PER_COMMAND && !a12);
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tick();
    @(posedge ref_clk);
    #1;
  endtask

  // Command, then idle slots; returns where the decode of the command is visible
  task automatic issue(input logic c, input logic [2:0] p, input logic ke,
                       input logic [2:0] b, input logic [15:0] d);
    dcd_ctrl_model_i.drive(c, p, ke, b, d);
    dcd_ctrl_model_i.drive(1'h0, `DCD_PAT_IDLE, ke, 3'h0, 16'h0000);
    @(posedge ref_clk);
    @(posedge ref_clk);
    #1;
  endtask

  // Counts cycles that the burst stands, from the decode cycle on
  task automatic burstLen(input logic [31:0] exp);
    cnt = 0;
    while (burstBusy === 1'h1 && cnt < 8) begin
      cnt++;
      tick();
    end
    check(cnt, exp);
  endtask

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Watchdog well beyond the expected run
  initial begin
    repeat (6000) @(posedge ref_clk);
    error_cnt++;
    test_done();
  end

  initial begin
    longSeen = 1'h0;
    openMask = 8'h00;
    repeat (8) @(posedge ref_clk);
    #1;
    check(pwrState_ff, PWR_ACTIVE);
    check(cmdCode_ff, CMD_NONE);
    @(posedge ref_clk) rst_b <= 1'h1;
    repeat (4) tick();
    // Per-command burst size in mode word zero
    mr0 = 16'h0001;
    issue(1'h0, `DCD_PAT_MODE_LOAD, 1'h1, 3'h0, mr0);
    check(cmdCode_ff, CMD_MODE_LOAD);
    tick();
    check(mode_register_zero, mr0);
    // Rows opened in two banks, one closed alone
    issue(1'h0, `DCD_PAT_ROW_OPEN, 1'h1, 3'h2, 16'h1234);
    issue(1'h0, `DCD_PAT_ROW_OPEN, 1'h1, 3'h5, 16'h4321);
    tick();
    check(bankOpen_ff, 8'h24);
    issue(1'h0, `DCD_PAT_PRECHARGE, 1'h1, 3'h2, 16'h0000);
    tick();
    check(bankOpen_ff, 8'h20);
    // Chopped read with auto precharge, second read lands during the burst
    dcd_ctrl_model_i.drive(1'h0, `DCD_PAT_READ, 1'h1, 3'h5, 16'h0400);
    dcd_ctrl_model_i.drive(1'h0, `DCD_PAT_READ, 1'h1, 3'h5, 16'h1000);
    dcd_ctrl_model_i.drive(1'h0, `DCD_PAT_IDLE, 1'h1, 3'h0, 16'h0000);
    tick();
    check(cmdCode_ff, CMD_READ);
    check(autoPrecharge_ff, 1'h1);
    check(chopped_four_burst_ff, 1'h1);
    tick();
    check(cmdCode_ff, CMD_NONE);
    check(cmdValid_ff, 1'h0);
    burstLen(32'd1);
    repeat (3) tick();
    check(bankOpen_ff, 8'h00);
    // Sleep power-down: entry, ignored refresh, exit by deselect
    issue(1'h0, `DCD_PAT_IDLE, 1'h0, 3'h0, 16'h0000);
    check(pwrState_ff, PWR_SLEEP);
    issue(1'h0, `DCD_PAT_REFRESH, 1'h0, 3'h0, 16'h0000);
    check(cmdValid_ff, 1'h0);
    check(pwrState_ff, PWR_SLEEP);
    issue(1'h1, `DCD_PAT_IDLE, 1'h1, 3'h0, 16'h0000);
    check(pwrState_ff, PWR_ACTIVE);
    check(cmdCode_ff, CMD_SLEEP_EXIT);
    // Self-renew: refresh with clock-enable falling, exit on clock-enable alone
    issue(1'h0, `DCD_PAT_REFRESH, 1'h0, 3'h0, 16'h0000);
    check(pwrState_ff, PWR_SELF);
    issue(1'h1, `DCD_PAT_IDLE, 1'h1, 3'h0, 16'h0000);
    check(pwrState_ff, PWR_ACTIVE);
    check(cmdCode_ff, CMD_SELF_RENEW_EXIT);
    // Random command stream; the controller keeps row-open discipline
    for (int n = 0; n < 60; n++) begin
      r = xs();
      cs = (r[3:0] == 4'hf);
      pat = r[6:4];
      ba = r[9:7];
      a = r[31:16];
      if (pat == `DCD_PAT_MODE_LOAD) ba[2] = 1'h0;
      if (!cs && pat == `DCD_PAT_ROW_OPEN && openMask[ba]) begin
        pat = `DCD_PAT_PRECHARGE;
        a[10] = 1'h0;
      end
      @(posedge ref_clk) termCtl <= r[10];
      e = expCmd(cs, pat, a[10]);
      chop = expChop(mr0, a[12]);
      issue(cs, pat, 1'h1, ba, a);
      check(cmdCode_ff, e);
      check(cmdValid_ff, e != CMD_IDLE);
      if (!cs) check(cmdBank_ff, ba);
      if (e == CMD_LONG_CALIBRATION) begin
        check({calInit_ff, calOper_ff}, {~longSeen, longSeen});
        longSeen = 1'h1;
      end
      if (e == CMD_SHORT_CALIBRATION) check(calShort_ff, 1'h1);
      if (e == CMD_ROW_OPEN) check(cmdRow_ff, a);
      if (e == CMD_READ || e == CMD_WRITE) check(cmdCol_ff, a[9:0]);
      if (e == CMD_ROW_OPEN) openMask[ba] = 1'h1;
      if (e == CMD_PRECHARGE) openMask[ba] = 1'h0;
      if (e == CMD_CLOSE_ALL_ROWS) openMask = 8'h00;
      if (e == CMD_MODE_LOAD && ba == 3'h0) mr0 = a;
      if (e == CMD_READ || e == CMD_WRITE) begin
        check(autoPrecharge_ff, a[10]);
        check(chopped_four_burst_ff, chop);
        burstLen(chop ? 32'd2 : 32'd4);
        if (a[10]) openMask[ba] = 1'h0;
      end
      repeat (2) tick();
      check(mode_register_zero, mr0);
      check(bankOpen_ff, openMask);
    end
    // Reset in mid-run clears state at once
    @(posedge ref_clk) rst_b <= 1'h0;
    tick();
    check(pwrState_ff, PWR_ACTIVE);
    check(mode_register_zero, 16'h0000);
    check(bankOpen_ff, 8'h00);
    @(posedge ref_clk) rst_b <= 1'h1;
    repeat (4) tick();
    issue(1'h0, `DCD_PAT_ROW_OPEN, 1'h1, 3'h7, 16'h00ff);
    check(cmdCode_ff, CMD_ROW_OPEN);
    test_done();
  end
endmodule // dcd_command_decoder_tb
